/* File: pkg/alsd_pkg.sv */
// alsd_pkg: opcode patterns, field positions, state and result encodings
// for the arithmetic/logic/string opcode decoder.
// assumes one clock domain and a byte stream from fetch logic on that clock.
`default_nettype none
package alsd_pkg;

  // field positions inside opcode and operand-form bytes
  localparam int W_BIT = 0;
  localparam int D_BIT = 1;
  localparam int S_BIT = 1;
  localparam int SIGN_BIT = 7;
  localparam logic [1:0] MOD_REG = 2'h3;
  localparam logic [2:0] RM_SIB = 3'h4;
  localparam logic [2:0] RM_DIRECT32 = 3'h5;
  localparam logic [2:0] RM_DIRECT16 = 3'h6;
  localparam logic [1:0] MOD_NONE = 2'h0;
  localparam logic [1:0] MOD_DISP8 = 2'h1;
  localparam logic [2:0] BASE_NONE = 3'h5;

  // masks: dw families, w families and the 011010s1 form
  localparam logic [7:0] MASK_DW = 8'hFC;
  localparam logic [7:0] MASK_W = 8'hFE;
  localparam logic [7:0] MASK_S1 = 8'hFD;

  // register/memory families (dw) and accumulator short forms (w)
  localparam logic [7:0] OPC_PLUS_RM = 8'h00;
  localparam logic [7:0] OPC_PLUS_ACC = 8'h04;
  localparam logic [7:0] OPC_CARRY_RM = 8'h10;
  localparam logic [7:0] OPC_CARRY_ACC = 8'h14;
  localparam logic [7:0] OPC_MINUS_RM = 8'h28;
  localparam logic [7:0] OPC_MINUS_ACC = 8'h2C;
  localparam logic [7:0] OPC_BORROW_RM = 8'h18;
  localparam logic [7:0] OPC_BORROW_ACC = 8'h1C;
  localparam logic [7:0] OPC_COMPARE_RM = 8'h38;
  localparam logic [7:0] OPC_COMPARE_ACC = 8'h3C;
  localparam logic [7:0] OPC_AND_RM = 8'h20;
  localparam logic [7:0] OPC_AND_ACC = 8'h24;
  localparam logic [7:0] OPC_OR_RM = 8'h08;
  localparam logic [7:0] OPC_OR_ACC = 8'h0C;
  localparam logic [7:0] OPC_XOR_RM = 8'h30;
  localparam logic [7:0] OPC_XOR_ACC = 8'h34;
  localparam logic [7:0] OPC_ARITH_GRP = 8'h80;
  localparam logic [7:0] OPC_UNARY_GRP = 8'hF6;
  localparam logic [7:0] OPC_TEST_RM = 8'h84;
  localparam logic [7:0] OPC_SPROD3 = 8'h69;
  localparam logic [7:0] OPC_SHIFT_ONE = 8'hD0;
  localparam logic [7:0] OPC_SHIFT_CL = 8'hD2;
  localparam logic [7:0] OPC_SHIFT_IMM = 8'hC0;
  // single bytes
  localparam logic [7:0] OPC_ESCAPE = 8'h0F;
  localparam logic [7:0] OPC_ASCII_MINUS = 8'h3F;
  localparam logic [7:0] OPC_DEC_PLUS = 8'h27;
  localparam logic [7:0] OPC_DEC_MINUS = 8'h2F;
  localparam logic [7:0] OPC_ASCII_QUOT = 8'hD5;
  localparam logic [7:0] OPC_ASCII_PROD = 8'hD4;
  localparam logic [7:0] OPC_BASE_TEN = 8'h0A;
  localparam logic [7:0] OPC_BYTE_WORD = 8'h98;
  localparam logic [7:0] OPC_WORD_DOUBLE = 8'h99;
  localparam logic [7:0] OPC_TRANSLATE = 8'hD7;
  localparam logic [7:0] PFX_REP_EQ = 8'hF3;
  localparam logic [7:0] PFX_REP_NE = 8'hF2;
  // string families (w)
  localparam logic [7:0] OPC_STR_COMPARE = 8'hA6;
  localparam logic [7:0] OPC_STR_COPY = 8'hA4;
  localparam logic [7:0] OPC_STR_SCAN = 8'hAE;
  localparam logic [7:0] OPC_STR_LOAD = 8'hAC;
  localparam logic [7:0] OPC_STR_STORE = 8'hAA;
  localparam logic [7:0] OPC_PORT_IN = 8'h6C;
  localparam logic [7:0] OPC_PORT_OUT = 8'h6E;
  // second bytes after the escape byte
  localparam logic [7:0] OPC2_SPROD = 8'hAF;
  localparam logic [7:0] OPC2_DLEFT_IMM = 8'hA4;
  localparam logic [7:0] OPC2_DLEFT_CL = 8'hA5;
  localparam logic [7:0] OPC2_DRIGHT_IMM = 8'hAC;
  localparam logic [7:0] OPC2_DRIGHT_CL = 8'hAD;

  localparam logic [2:0] SHIFT_UNASSIGNED = 3'h6;

  typedef enum logic [2:0] {
    ST_FIRST = 3'b000, ST_ESC = 3'b001, ST_BASE10 = 3'b010, ST_MODRM = 3'b011,
    ST_SIB = 3'b100, ST_DISP = 3'b101, ST_IMM = 3'b110
  } alsd_state_t;

  typedef enum logic [5:0] {
    OP_NONE = 6'b000000, OP_PLUS = 6'b000001, OP_PLUS_CARRY = 6'b000010,
    OP_MINUS = 6'b000011, OP_MINUS_BORROW = 6'b000100, OP_COMPARE = 6'b000101,
    OP_AND = 6'b000110, OP_OR = 6'b000111, OP_XOR = 6'b001000, OP_TEST = 6'b001001,
    OP_INVERT = 6'b001010, OP_TWOS = 6'b001011, OP_UPROD = 6'b001100,
    OP_SPROD = 6'b001101, OP_UQUOT = 6'b001110, OP_SQUOT = 6'b001111,
    OP_ASCII_FIX_MINUS = 6'b010000, OP_DEC_FIX_PLUS = 6'b010001,
    OP_DEC_FIX_MINUS = 6'b010010, OP_ASCII_BEFORE_QUOT = 6'b010011,
    OP_ASCII_AFTER_PROD = 6'b010100, OP_BYTE_WORD = 6'b010101,
    OP_WORD_DOUBLE = 6'b010110, OP_SHIFT = 6'b010111, OP_DSHIFT_LEFT = 6'b011000,
    OP_DSHIFT_RIGHT = 6'b011001, OP_STR_COMPARE = 6'b011010, OP_STR_COPY = 6'b011011,
    OP_STR_SCAN = 6'b011100, OP_STR_LOAD = 6'b011101, OP_STR_STORE = 6'b011110,
    OP_PORT_IN = 6'b011111, OP_PORT_OUT = 6'b100000, OP_TRANSLATE = 6'b100001,
    OP_ILLEGAL = 6'b111111
  } alsd_op_t;

  typedef enum logic [1:0] {
    GRP_NONE = 2'b00, GRP_ARITH = 2'b01, GRP_UNARY = 2'b10, GRP_SHIFT = 2'b11
  } alsd_grp_t;

  typedef enum logic [1:0] {
    IMM_NONE = 2'b00, IMM_FULL = 2'b01, IMM_BYTE = 2'b10, IMM_SEXT = 2'b11
  } alsd_imm_t;

  typedef enum logic [1:0] {
    CNT_NONE = 2'b00, CNT_ONE = 2'b01, CNT_CL = 2'b10, CNT_IMM = 2'b11
  } alsd_cnt_t;

  typedef enum logic [1:0] {
    REP_NONE = 2'b00, REP_PLAIN = 2'b01, REP_WHILE_EQ = 2'b10, REP_WHILE_NE = 2'b11
  } alsd_rep_t;

endpackage : alsd_pkg
`default_nettype wire

/* File: hw/alsd_decoder.sv */
// alsd_decoder: classifies arithmetic, logic, shift and string opcode
// sequences one byte per accepted cycle and reports one result pulse.
// assumes fetch logic on the same clock; no prefixes other than repeat.
//
// Summary of operation
// - minus recognised from 001010dw pairs and 0010110w accumulator immediate.
// - 100000sw picks its operation from the operand byte middle field.
// - minus with borrow from 000110dw pairs and 0001110w accumulator immediate.
// - compare from 001110dw and 0011110w; it only updates flags.
// - 1111011w selects test, invert, negate, products or quotients by field.
// - signed product as escape then 10101111, or 011010s1 with immediate.
// - single bytes map to ascii fix after minus and decimal fixes.
// - 11010101 or 11010100 followed by 00001010 are ascii fixes.
// - 10011000 and 10011001 are the sign-extension converts.
// - shift by one, by count register, or by an 8-bit immediate.
// - shift kind field decoded; code 110 is unassigned.
// - double left shift by immediate or by count register.
// - double right shift by immediate or by count register.
// - bitwise and, or, xor pair forms and accumulator immediate forms.
// - 1000010w is a bitwise test writing no result.
// - string compare, copy and scan single bytes.
// - string load into accumulator and store from accumulator.
// - string port input and output use the port pointer register.
// - 11010111 is the table lookup translate.
// - repeated string operations count in the 16 or 32-bit counter.
// - repeat prefixes on compare stop at mismatch or at match.
`default_nettype none
module alsd_decoder
  import alsd_pkg::*;
#(
  parameter logic [2:0] OPER_BYTES = 3'h4,
  parameter bit ADDR_WIDE = 1'b1
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  output logic byte_ready,
  output logic dec_valid,
  output alsd_op_t dec_op,
  output logic [2:0] dec_shift_kind,
  output alsd_cnt_t dec_count_src,
  output alsd_rep_t dec_rep,
  output logic dec_full_size,
  output logic dec_to_reg,
  output logic dec_sext,
  output logic [7:0] dec_modrm,
  output logic [31:0] dec_imm,
  output logic [3:0] dec_len,
  output logic dec_writes_result,
  output logic dec_uses_port_reg,
  output logic dec_counter_wide
);

  typedef struct packed {
    alsd_state_t state;
    logic busy;
    logic vld;
    alsd_op_t op;
    alsd_grp_t grp;
    alsd_imm_t immk;
    alsd_cnt_t cnt;
    alsd_rep_t rep;
    logic [1:0] pfx;
    logic [2:0] kind;
    logic w;
    logic d;
    logic s;
    logic sib;
    logic [7:0] modrm;
    logic [31:0] imm;
    logic [1:0] imm_idx;
    logic [2:0] imm_cnt;
    logic [2:0] disp_cnt;
    logic [3:0] len;
  } alsd_st_t;

  localparam logic [1:0] PFX_NONE = 2'b00;
  localparam logic [1:0] PFX_EQ = 2'b01;
  localparam logic [1:0] PFX_NE = 2'b10;

  alsd_st_t st_q;
  alsd_st_t st_d;
  logic take;

  function automatic logic fam(input logic [7:0] b, input logic [7:0] pat,
                               input logic [7:0] mask);
    fam = (b & mask) == pat;
  endfunction : fam

  function automatic logic [2:0] imm_len(input alsd_imm_t k, input logic w, input logic s);
    logic [2:0] full;
    full = w ? OPER_BYTES : 3'h1;
    case (k)
      IMM_BYTE: imm_len = 3'h1;
      IMM_FULL: imm_len = full;
      IMM_SEXT: imm_len = s ? 3'h1 : full;
      default: imm_len = 3'h0;
    endcase
  endfunction : imm_len

  function automatic logic [2:0] disp_len(input logic [1:0] md, input logic [2:0] rm);
    logic [2:0] wide;
    wide = ADDR_WIDE ? 3'h4 : 3'h2;
    if (md == MOD_REG) begin
      disp_len = 3'h0;
    end else if (md == MOD_DISP8) begin
      disp_len = 3'h1;
    end else if (md == MOD_NONE) begin
      disp_len = (rm == (ADDR_WIDE ? RM_DIRECT32 : RM_DIRECT16)) ? wide : 3'h0;
    end else begin
      disp_len = wide;
    end
  endfunction : disp_len

  function automatic alsd_op_t arith_op(input logic [2:0] f);
    case (f)
      3'h0: arith_op = OP_PLUS;
      3'h1: arith_op = OP_OR;
      3'h2: arith_op = OP_PLUS_CARRY;
      3'h3: arith_op = OP_MINUS_BORROW;
      3'h4: arith_op = OP_AND;
      3'h5: arith_op = OP_MINUS;
      3'h6: arith_op = OP_XOR;
      default: arith_op = OP_COMPARE;
    endcase
  endfunction : arith_op

  function automatic alsd_op_t unary_op(input logic [2:0] f);
    case (f)
      3'h0: unary_op = OP_TEST;
      3'h2: unary_op = OP_INVERT;
      3'h3: unary_op = OP_TWOS;
      3'h4: unary_op = OP_UPROD;
      3'h5: unary_op = OP_SPROD;
      3'h6: unary_op = OP_UQUOT;
      3'h7: unary_op = OP_SQUOT;
      default: unary_op = OP_ILLEGAL;
    endcase
  endfunction : unary_op

  function automatic logic is_string(input alsd_op_t o);
    is_string = (o >= OP_STR_COMPARE) && (o <= OP_PORT_OUT);
  endfunction : is_string

  assign take = clk_en && byte_valid;
  assign byte_ready = clk_en;

  always_comb begin
    logic adv;
    logic fin;
    logic [1:0] md;
    logic [2:0] reg_f;
    logic [2:0] rm;
    logic [7:0] b;
    adv = 1'b0;
    fin = 1'b0;
    b = byte_data;
    md = b[7:6];
    reg_f = b[5:3];
    rm = b[2:0];
    st_d = st_q;
    st_d.vld = 1'b0;
    if (take) begin
      st_d.busy = 1'b1;
      st_d.len = st_q.busy ? st_q.len + 4'h1 : 4'h1;
      case (st_q.state)
        ST_FIRST: begin
          if (b == PFX_REP_EQ) begin
            st_d.pfx = PFX_EQ;
          end else if (b == PFX_REP_NE) begin
            st_d.pfx = PFX_NE;
          end else begin
            st_d.w = b[W_BIT];
            st_d.d = 1'b0;
            st_d.s = 1'b0;
            st_d.grp = GRP_NONE;
            st_d.immk = IMM_NONE;
            st_d.cnt = CNT_NONE;
            st_d.kind = 3'h0;
            st_d.sib = 1'b0;
            st_d.modrm = 8'h00;
            st_d.imm = 32'h0000_0000;
            st_d.imm_idx = 2'h0;
            st_d.disp_cnt = 3'h0;
            st_d.state = ST_MODRM;
            if (fam(b, OPC_MINUS_RM, MASK_DW) || fam(b, OPC_BORROW_RM, MASK_DW) ||
                fam(b, OPC_COMPARE_RM, MASK_DW) || fam(b, OPC_AND_RM, MASK_DW) ||
                fam(b, OPC_OR_RM, MASK_DW) || fam(b, OPC_XOR_RM, MASK_DW) ||
                fam(b, OPC_PLUS_RM, MASK_DW) || fam(b, OPC_CARRY_RM, MASK_DW)) begin
              st_d.d = b[D_BIT];
              if (fam(b, OPC_MINUS_RM, MASK_DW)) st_d.op = OP_MINUS;
              else if (fam(b, OPC_BORROW_RM, MASK_DW)) st_d.op = OP_MINUS_BORROW;
              else if (fam(b, OPC_COMPARE_RM, MASK_DW)) st_d.op = OP_COMPARE;
              else if (fam(b, OPC_AND_RM, MASK_DW)) st_d.op = OP_AND;
              else if (fam(b, OPC_OR_RM, MASK_DW)) st_d.op = OP_OR;
              else if (fam(b, OPC_XOR_RM, MASK_DW)) st_d.op = OP_XOR;
              else if (fam(b, OPC_PLUS_RM, MASK_DW)) st_d.op = OP_PLUS;
              else st_d.op = OP_PLUS_CARRY;
            end else if (fam(b, OPC_ARITH_GRP, MASK_DW)) begin
              st_d.s = b[S_BIT];
              st_d.grp = GRP_ARITH;
              st_d.immk = IMM_SEXT;
            end else if (fam(b, OPC_UNARY_GRP, MASK_W)) begin
              st_d.grp = GRP_UNARY;
            end else if (fam(b, OPC_TEST_RM, MASK_W)) begin
              st_d.op = OP_TEST;
            end else if (fam(b, OPC_SPROD3, MASK_S1)) begin
              st_d.op = OP_SPROD;
              st_d.s = b[S_BIT];
              st_d.immk = IMM_SEXT;
            end else if (fam(b, OPC_SHIFT_ONE, MASK_W)) begin
              st_d.grp = GRP_SHIFT;
              st_d.cnt = CNT_ONE;
            end else if (fam(b, OPC_SHIFT_CL, MASK_W)) begin
              st_d.grp = GRP_SHIFT;
              st_d.cnt = CNT_CL;
            end else if (fam(b, OPC_SHIFT_IMM, MASK_W)) begin
              st_d.grp = GRP_SHIFT;
              st_d.cnt = CNT_IMM;
              st_d.immk = IMM_BYTE;
            end else if (b == OPC_ESCAPE) begin
              st_d.state = ST_ESC;
            end else if (b == OPC_ASCII_QUOT || b == OPC_ASCII_PROD) begin
              st_d.op = (b == OPC_ASCII_QUOT) ? OP_ASCII_BEFORE_QUOT : OP_ASCII_AFTER_PROD;
              st_d.state = ST_BASE10;
            end else begin
              adv = 1'b1;
              if (fam(b, OPC_MINUS_ACC, MASK_W)) begin
                st_d.op = OP_MINUS;
                st_d.immk = IMM_FULL;
              end else if (fam(b, OPC_BORROW_ACC, MASK_W)) begin
                st_d.op = OP_MINUS_BORROW;
                st_d.immk = IMM_FULL;
              end else if (fam(b, OPC_COMPARE_ACC, MASK_W)) begin
                st_d.op = OP_COMPARE;
                st_d.immk = IMM_FULL;
              end else if (fam(b, OPC_AND_ACC, MASK_W) || fam(b, OPC_OR_ACC, MASK_W) ||
                           fam(b, OPC_XOR_ACC, MASK_W)) begin
                st_d.op = fam(b, OPC_AND_ACC, MASK_W) ? OP_AND :
                          fam(b, OPC_OR_ACC, MASK_W) ? OP_OR : OP_XOR;
                st_d.immk = IMM_FULL;
              end else if (fam(b, OPC_PLUS_ACC, MASK_W) || fam(b, OPC_CARRY_ACC, MASK_W)) begin
                st_d.op = fam(b, OPC_PLUS_ACC, MASK_W) ? OP_PLUS : OP_PLUS_CARRY;
                st_d.immk = IMM_FULL;
              end else if (b == OPC_ASCII_MINUS) st_d.op = OP_ASCII_FIX_MINUS;
              else if (b == OPC_DEC_PLUS) st_d.op = OP_DEC_FIX_PLUS;
              else if (b == OPC_DEC_MINUS) st_d.op = OP_DEC_FIX_MINUS;
              else if (b == OPC_BYTE_WORD) st_d.op = OP_BYTE_WORD;
              else if (b == OPC_WORD_DOUBLE) st_d.op = OP_WORD_DOUBLE;
              else if (b == OPC_TRANSLATE) st_d.op = OP_TRANSLATE;
              else if (fam(b, OPC_STR_COMPARE, MASK_W)) st_d.op = OP_STR_COMPARE;
              else if (fam(b, OPC_STR_COPY, MASK_W)) st_d.op = OP_STR_COPY;
              else if (fam(b, OPC_STR_SCAN, MASK_W)) st_d.op = OP_STR_SCAN;
              else if (fam(b, OPC_STR_LOAD, MASK_W)) st_d.op = OP_STR_LOAD;
              else if (fam(b, OPC_STR_STORE, MASK_W)) st_d.op = OP_STR_STORE;
              else if (fam(b, OPC_PORT_IN, MASK_W)) st_d.op = OP_PORT_IN;
              else if (fam(b, OPC_PORT_OUT, MASK_W)) st_d.op = OP_PORT_OUT;
              else st_d.op = OP_ILLEGAL;
              st_d.imm_cnt = imm_len(st_d.immk, st_d.w, st_d.s);
            end
          end
        end
        ST_ESC: begin
          st_d.state = ST_MODRM;
          st_d.w = 1'b1;
          if (b == OPC2_SPROD) begin
            st_d.op = OP_SPROD;
          end else if (b == OPC2_DLEFT_IMM || b == OPC2_DLEFT_CL) begin
            st_d.op = OP_DSHIFT_LEFT;
            st_d.cnt = (b == OPC2_DLEFT_IMM) ? CNT_IMM : CNT_CL;
            st_d.immk = (b == OPC2_DLEFT_IMM) ? IMM_BYTE : IMM_NONE;
          end else if (b == OPC2_DRIGHT_IMM || b == OPC2_DRIGHT_CL) begin
            st_d.op = OP_DSHIFT_RIGHT;
            st_d.cnt = (b == OPC2_DRIGHT_IMM) ? CNT_IMM : CNT_CL;
            st_d.immk = (b == OPC2_DRIGHT_IMM) ? IMM_BYTE : IMM_NONE;
          end else begin
            st_d.op = OP_ILLEGAL;
            fin = 1'b1;
          end
        end
        ST_BASE10: begin
          if (b != OPC_BASE_TEN) st_d.op = OP_ILLEGAL;
          fin = 1'b1;
        end
        ST_MODRM: begin
          st_d.modrm = b;
          if (st_q.grp == GRP_ARITH) begin
            st_d.op = arith_op(reg_f);
          end else if (st_q.grp == GRP_UNARY) begin
            st_d.op = unary_op(reg_f);
            st_d.immk = (reg_f == 3'h0) ? IMM_FULL : IMM_NONE;
          end else if (st_q.grp == GRP_SHIFT) begin
            st_d.kind = reg_f;
            st_d.op = (reg_f == SHIFT_UNASSIGNED) ? OP_ILLEGAL : OP_SHIFT;
          end
          // address bytes are counted before any immediate bytes
          st_d.sib = ADDR_WIDE && md != MOD_REG && rm == RM_SIB;
          st_d.disp_cnt = disp_len(md, rm);
          st_d.imm_cnt = imm_len(st_d.immk, st_d.w, st_d.s);
          adv = 1'b1;
        end
        ST_SIB: begin
          st_d.sib = 1'b0;
          if (st_q.modrm[7:6] == MOD_NONE && rm == BASE_NONE) st_d.disp_cnt = 3'h4;
          adv = 1'b1;
        end
        ST_DISP: begin
          st_d.disp_cnt = st_q.disp_cnt - 3'h1;
          adv = 1'b1;
        end
        default: begin
          // immediate data, low byte first; a lone s-form byte is sign-extended
          if (st_q.immk == IMM_SEXT && st_q.s) begin
            st_d.imm = {{24{b[SIGN_BIT]}}, b};
          end else begin
            st_d.imm[{st_q.imm_idx, 3'h0} +: 8] = b;
          end
          st_d.imm_idx = st_q.imm_idx + 2'h1;
          st_d.imm_cnt = st_q.imm_cnt - 3'h1;
          adv = 1'b1;
        end
      endcase
      if (adv) begin
        if (st_d.sib) st_d.state = ST_SIB;
        else if (st_d.disp_cnt != 3'h0) st_d.state = ST_DISP;
        else if (st_d.imm_cnt != 3'h0) st_d.state = ST_IMM;
        else fin = 1'b1;
      end
      if (fin) begin
        st_d.state = ST_FIRST;
        st_d.vld = 1'b1;
        st_d.busy = 1'b0;
        st_d.rep = REP_NONE;
        if (st_q.pfx != PFX_NONE && is_string(st_d.op)) begin
          if (st_d.op == OP_STR_COMPARE || st_d.op == OP_STR_SCAN) begin
            st_d.rep = (st_q.pfx == PFX_EQ) ? REP_WHILE_EQ : REP_WHILE_NE;
          end else begin
            st_d.rep = REP_PLAIN;
          end
        end
        st_d.pfx = PFX_NONE;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign dec_valid = st_q.vld;
  assign dec_op = st_q.op;
  assign dec_shift_kind = st_q.kind;
  assign dec_count_src = st_q.cnt;
  assign dec_rep = st_q.rep;
  assign dec_full_size = st_q.w;
  assign dec_to_reg = st_q.d;
  assign dec_sext = st_q.s;
  assign dec_modrm = st_q.modrm;
  assign dec_imm = st_q.imm;
  assign dec_len = st_q.len;
  assign dec_writes_result = st_q.op != OP_COMPARE && st_q.op != OP_TEST;
  assign dec_uses_port_reg = st_q.op == OP_PORT_IN || st_q.op == OP_PORT_OUT;
  assign dec_counter_wide = ADDR_WIDE;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_fresh(logic [7:0] v);
    take && st_q.state == ST_FIRST && !st_q.busy && byte_data == v;
  endsequence

  a_minus_short: assert property (s_fresh(OPC_MINUS_ACC) ##1 take |=>
      dec_valid && dec_op == OP_MINUS && dec_len == 4'h2)
    else $error("byte-form minus short form not decoded in two bytes");
  a_compare_flags: assert property (dec_valid && dec_op == OP_COMPARE |->
      !dec_writes_result)
    else $error("compare reported as writing a result");
  a_test_flags: assert property (dec_valid && dec_op == OP_TEST |-> !dec_writes_result)
    else $error("test reported as writing a result");
  a_ascii_minus: assert property (s_fresh(OPC_ASCII_MINUS) |=>
      dec_valid && dec_op == OP_ASCII_FIX_MINUS && dec_len == 4'h1)
    else $error("ascii fix after minus not decoded");
  a_ascii_quot: assert property (s_fresh(OPC_ASCII_QUOT) ##1 (take &&
      byte_data == OPC_BASE_TEN) |=> dec_valid && dec_op == OP_ASCII_BEFORE_QUOT)
    else $error("ascii fix before quotient not decoded");
  a_shift_kind: assert property (dec_valid && dec_op == OP_SHIFT |->
      dec_shift_kind != SHIFT_UNASSIGNED)
    else $error("unassigned shift kind accepted");
  a_repeat_equal: assert property (s_fresh(PFX_REP_EQ) ##1 (take &&
      byte_data == OPC_STR_COMPARE) |=> dec_valid && dec_rep == REP_WHILE_EQ)
    else $error("repeat while equal not attached to string compare");
  a_port_pointer: assert property (dec_valid && dec_op inside {OP_PORT_IN, OP_PORT_OUT}
      |-> dec_uses_port_reg && dec_writes_result)
    else $error("port string op without port pointer");
  a_translate: assert property (s_fresh(OPC_TRANSLATE) |=> dec_valid &&
      dec_op == OP_TRANSLATE && dec_len == 4'h1)
    else $error("translate not decoded");
  a_rep_string: assert property (dec_valid && dec_rep != REP_NONE |->
      is_string(dec_op) && dec_counter_wide == ADDR_WIDE)
    else $error("repeat marked on a non-string op");

endmodule : alsd_decoder
`default_nettype wire

/* File: test/alsd_fetch_model.sv */
// alsd_fetch_model: fetch side, offers queued bytes one per cycle.
// assumes the bench pushes q after a rising edge and clk_en stays high.
`default_nettype none
module alsd_fetch_model (
  input wire logic clock,
  input wire logic resetn,
  output logic byte_valid,
  output logic [7:0] byte_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] q[$];
  initial begin
    byte_valid = 1'b0;
    byte_data = 8'h00;
  end
  // idle lines alternate each cycle between the inverse of the last byte and the byte itself
  always @(negedge clock) begin
    if (resetn && q.size() > 0) begin
      byte_valid <= 1'b1;
      byte_data <= q.pop_front();
    end else begin
      byte_valid <= 1'b0;
      byte_data <= ~byte_data;
    end
  end
endmodule : alsd_fetch_model
`default_nettype wire

/* File: test/alsd_decoder_tb_top.sv */
// alsd_decoder_tb_top: feeds opcode sequences, checks each decode.
// assumes default parameters: 4-byte operands, 32-bit addressing.
`default_nettype none
module alsd_decoder_tb_top
  import alsd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic byte_valid, byte_ready, dec_valid, dec_full_size, dec_to_reg, dec_sext;
  logic dec_writes_result, dec_uses_port_reg, dec_counter_wide;
  logic [7:0] byte_data, dec_modrm;
  logic [2:0] dec_shift_kind;
  logic [31:0] dec_imm;
  logic [3:0] dec_len;
  alsd_op_t dec_op;
  alsd_cnt_t dec_count_src;
  alsd_rep_t dec_rep;
  int mismatches = 0;
  int samples_checked = 0;
  alsd_decoder i_alsd_decoder (.clock(clock), .resetn(resetn), .clk_en(1'b1),
    .byte_valid(byte_valid), .byte_data(byte_data), .byte_ready(byte_ready),
    .dec_valid(dec_valid), .dec_op(dec_op), .dec_shift_kind(dec_shift_kind),
    .dec_count_src(dec_count_src), .dec_rep(dec_rep), .dec_full_size(dec_full_size),
    .dec_to_reg(dec_to_reg), .dec_sext(dec_sext), .dec_modrm(dec_modrm),
    .dec_imm(dec_imm), .dec_len(dec_len), .dec_writes_result(dec_writes_result),
    .dec_uses_port_reg(dec_uses_port_reg), .dec_counter_wide(dec_counter_wide));
  alsd_fetch_model i_alsd_fetch_model (.clock(clock), .resetn(resetn),
    .byte_valid(byte_valid), .byte_data(byte_data));
  always #50 clock = ~clock;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // first byte sits in the most significant of the n bytes given
  task automatic dec(input int n, input logic [47:0] b, input alsd_op_t op,
                     input logic [3:0] len);
    int i;
    @(posedge clock);
    for (i = 0; i < n; i++) i_alsd_fetch_model.q.push_back(b[8*(n-1-i) +: 8]);
    i = 0;
    do begin
      @(negedge clock);
      i++;
    end while (dec_valid !== 1'b1 && i < 20);
    chk("valid", 1, dec_valid);
    chk("op", op, dec_op);
    chk("len", len, dec_len);
  endtask : dec
  task automatic t_arith;
    alsd_op_t u[6] = '{OP_INVERT, OP_TWOS, OP_UPROD, OP_SPROD, OP_UQUOT, OP_SQUOT};
    dec(5, 48'h2D34120000, OP_MINUS, 4'h5);
    chk("imm", 32'h00001234, dec_imm);
    dec(2, 48'h2C05, OP_MINUS, 4'h2);
    chk("imm", 32'h00000005, dec_imm);
    dec(4, 48'h2B442408, OP_MINUS, 4'h4);
    chk("modrm", 8'h44, dec_modrm);
    chk("ready", 1, byte_ready);
    dec(3, 48'h83D8FF, OP_MINUS_BORROW, 4'h3);
    chk("imm", 32'hFFFFFFFF, dec_imm);
    chk("sext", 1, dec_sext);
    chk("modrm", 8'hD8, dec_modrm);
    dec(2, 48'h1C7F, OP_MINUS_BORROW, 4'h2);
    chk("full", 0, dec_full_size);
    dec(2, 48'hF7C8, OP_ILLEGAL, 4'h2);
    dec(6, 48'h3B0578563412, OP_COMPARE, 4'h6);
    chk("to_reg", 1, dec_to_reg);
    chk("writes", 0, dec_writes_result);
    dec(3, 48'hF6C055, OP_TEST, 4'h3);
    for (int f = 0; f < 6; f++) dec(2, {32'h0, 8'hF7, 2'b11, 3'(f + 2), 3'h0}, u[f], 4'h2);
    $display("arith done");
  endtask : t_arith
  task automatic t_misc;
    dec(3, 48'h0FAFC0, OP_SPROD, 4'h3);
    dec(3, 48'h6BC0FE, OP_SPROD, 4'h3);
    chk("imm", 32'hFFFFFFFE, dec_imm);
    dec(4, 48'h0FA4C005, OP_DSHIFT_LEFT, 4'h4);
    chk("cnt", CNT_IMM, dec_count_src);
    dec(3, 48'h0FADC0, OP_DSHIFT_RIGHT, 4'h3);
    chk("cnt", CNT_CL, dec_count_src);
    dec(1, 48'h3F, OP_ASCII_FIX_MINUS, 4'h1);
    dec(1, 48'h27, OP_DEC_FIX_PLUS, 4'h1);
    dec(1, 48'h2F, OP_DEC_FIX_MINUS, 4'h1);
    dec(2, 48'hD50A, OP_ASCII_BEFORE_QUOT, 4'h2);
    dec(2, 48'hD40A, OP_ASCII_AFTER_PROD, 4'h2);
    dec(1, 48'h98, OP_BYTE_WORD, 4'h1);
    dec(1, 48'h99, OP_WORD_DOUBLE, 4'h1);
    dec(1, 48'hD7, OP_TRANSLATE, 4'h1);
    // back to back: the second byte is taken while the first result stands
    dec(2, 48'h3FD7, OP_ASCII_FIX_MINUS, 4'h1);
    @(negedge clock);
    chk("next valid", 1, dec_valid);
    chk("next op", OP_TRANSLATE, dec_op);
    chk("next len", 1, dec_len);
    dec(2, 48'hD50B, OP_ILLEGAL, 4'h2);
    $display("misc done");
  endtask : t_misc
  task automatic t_shift_logic;
    for (int k = 0; k < 8; k++) begin
      dec(3, {24'h0, 8'hC1, 2'b11, 3'(k), 3'h0, 8'h03}, k == 6 ? OP_ILLEGAL : OP_SHIFT, 4'h3);
      if (k != 6) chk("kind", k, dec_shift_kind);
    end
    dec(2, 48'hD0E0, OP_SHIFT, 4'h2);
    chk("cnt", CNT_ONE, dec_count_src);
    dec(2, 48'hD3F8, OP_SHIFT, 4'h2);
    chk("cnt", CNT_CL, dec_count_src);
    dec(2, 48'h21C0, OP_AND, 4'h2);
    dec(5, 48'h0D01020304, OP_OR, 4'h5);
    dec(2, 48'h34AA, OP_XOR, 4'h2);
    dec(2, 48'h85C0, OP_TEST, 4'h2);
    chk("writes", 0, dec_writes_result);
    $display("shift logic done");
  endtask : t_shift_logic
  task automatic t_string;
    alsd_op_t so[7] = '{OP_STR_COMPARE, OP_STR_COPY, OP_STR_SCAN, OP_STR_LOAD,
                        OP_STR_STORE, OP_PORT_IN, OP_PORT_OUT};
    logic [7:0] sb[7] = '{8'hA6, 8'hA5, 8'hAE, 8'hAD, 8'hAA, 8'h6C, 8'h6F};
    for (int i = 0; i < 7; i++) begin
      dec(1, {40'h0, sb[i]}, so[i], 4'h1);
      chk("port", i > 4, dec_uses_port_reg);
    end
    dec(2, 48'hF3A6, OP_STR_COMPARE, 4'h2);
    chk("rep", REP_WHILE_EQ, dec_rep);
    dec(3, 48'hF3F2A7, OP_STR_COMPARE, 4'h3);
    chk("rep", REP_WHILE_NE, dec_rep);
    dec(2, 48'hF3AB, OP_STR_STORE, 4'h2);
    chk("rep", REP_PLAIN, dec_rep);
    chk("wide", 1, dec_counter_wide);
    $display("string done");
  endtask : t_string
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  initial begin
    repeat (5) @(negedge clock);
    resetn = 1'b1;
    t_arith;
    t_misc;
    t_shift_logic;
    t_string;
    summarize;
  end
  initial begin
    #200000;
    mismatches++;
    summarize;
  end
endmodule : alsd_decoder_tb_top
`default_nettype wire
